// ---- strap_pkg.sv ----
// shared types and constants for the soft-strap default logic
package strap_pkg;

	// port 0 operating mode, hard strap code
	typedef enum logic [1:0] {
		MODE_MII_MAC = 2'h0,
		MODE_MII_PHY = 2'h1,
		MODE_RMII_PHY = 2'h2,
		MODE_RESERVED = 2'h3
	} p0_mode_t;

	// soft strap values, from pins or from the eeprom loader
	typedef struct packed {
		logic p2_manual_pause_select_default;
		logic p0_speed_100_default;
		logic indication_pin_a_pol_default;
		logic p0_backpressure_default;
		logic p0_full_duplex_pause_default;
		logic p0_manual_pause_select_default;
		logic p0_heartbeat_test_off_default;
	} soft_straps_t;

	// register bits whose reset values come from the straps
	typedef struct packed {
		logic p0_manual_pause_select;
		logic p0_backpressure_enable;
		logic p0_transmit_pause_enable;
		logic p0_receive_pause_enable;
		logic p2_manual_pause_select;
		logic [1:0] internal_phy_advertisement;
		logic [1:0] virtual_phy_advertisement;
		logic [5:0] virtual_phy_partner_ability;
		logic heartbeat_test_off;
	} strap_regs_t;

	// software write port targets
	typedef enum logic [2:0] {
		SEL_P0_FLOW = 3'h0,
		SEL_P2_FLOW = 3'h1,
		SEL_PHY_ADV = 3'h2,
		SEL_VPHY_ADV = 3'h3,
		SEL_VPHY_PARTNER = 3'h4,
		SEL_VPHY_SPECIAL = 3'h5
	} write_sel_t;

	typedef struct packed {
		logic valid;
		write_sel_t sel;
		logic [5:0] data;
	} sw_write_t;

	// field positions in the partner ability and advertisement fields
	localparam int ABIL_ASYM = 5;
	localparam int ABIL_PAUSE = 4;
	localparam int ABIL_100FD = 3;
	localparam int ABIL_100HD = 2;
	localparam int ABIL_10FD = 1;
	localparam int ABIL_10HD = 0;
	localparam int ADV_ASYM = 1;
	localparam int ADV_SYM = 0;

	// strap values used when the pins float at their defaults
	localparam soft_straps_t STRAP_RESET = '{
		p2_manual_pause_select_default: 1'b0,
		p0_speed_100_default: 1'b1,
		indication_pin_a_pol_default: 1'b0,
		p0_backpressure_default: 1'b1,
		p0_full_duplex_pause_default: 1'b1,
		p0_manual_pause_select_default: 1'b0,
		p0_heartbeat_test_off_default: 1'b0
	};

	// register values held while reset is asserted
	localparam strap_regs_t REGS_RESET = '{
		p0_manual_pause_select: 1'b0,
		p0_backpressure_enable: 1'b1,
		p0_transmit_pause_enable: 1'b1,
		p0_receive_pause_enable: 1'b1,
		p2_manual_pause_select: 1'b0,
		internal_phy_advertisement: 2'h3,
		virtual_phy_advertisement: 2'h3,
		virtual_phy_partner_ability: 6'h35,
		heartbeat_test_off: 1'b0
	};

endpackage : strap_pkg

// ---- strap_capture.sv ----
// strap pin synchroniser, reset-time latch and eeprom override
module strap_capture (
	input wire logic sys_clk,
	input wire logic reset,
	input wire strap_pkg::soft_straps_t strap_pins,
	input wire logic [1:0] mode_pins,
	input wire logic indication_pin_a,
	input wire logic ee_load,
	input wire strap_pkg::soft_straps_t ee_straps,
	output strap_pkg::soft_straps_t straps_q,
	output strap_pkg::p0_mode_t mode_q,
	output logic indication_sync,
	output logic load_defaults_q
);
	import strap_pkg::*;

	soft_straps_t pins_s1_q;
	soft_straps_t pins_s2_q;
	logic [1:0] mode_s1_q;
	logic [1:0] mode_s2_q;
	logic ind_s1_q;
	logic ind_s2_q;
	logic reset_q;

	// two-flop synchronisers; only the second stage is read
	always_ff @(posedge sys_clk) begin
		pins_s1_q <= strap_pins;
		pins_s2_q <= pins_s1_q;
		mode_s1_q <= mode_pins;
		mode_s2_q <= mode_s1_q;
		ind_s1_q <= indication_pin_a;
		ind_s2_q <= ind_s1_q;
	end

	assign indication_sync = ind_s2_q;

	// soft straps follow pins during reset, then the loader may replace them
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			straps_q <= pins_s2_q;
		end else if (ee_load) begin
			straps_q <= ee_straps;
			// polarity strap has a dedicated pin, the loader cannot move it
			straps_q.indication_pin_a_pol_default <= straps_q.indication_pin_a_pol_default;
		end
	end

	// hard mode strap is caught during reset only
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mode_q <= p0_mode_t'(mode_s2_q);
		end
	end

	// one-cycle load request after reset release or a loader update
	always_ff @(posedge sys_clk) begin
		reset_q <= reset;
		if (reset) begin
			load_defaults_q <= 1'b0;
		end else begin
			load_defaults_q <= reset_q | ee_load;
		end
	end

endmodule : strap_capture

// ---- port_flow_strap_defaults.sv ----
// soft-strap defaults for port 0 and port 2 flow control and virtual phy bits
// Notes on behaviour
// - The port 2 manual pause strap sets the reset value of the port 2 manual select bit, default 0.
// - The port 2 manual pause strap also shapes the port 2 phy pause advertisement defaults.
// - The port 0 speed strap, default 1, shapes the two 100 Mbit partner ability bits.
// - When virtual auto-negotiation fails, port 0 runs at the strapped speed.
// - In mii mac mode the duplex polarity strap sets how the duplex indication pin is read.
// - The duplex polarity strap comes from its own pin and shapes the two full-duplex partner ability bits.
// - The port 0 backpressure strap, default 1, sets the backpressure enable reset value.
// - The port 0 full-duplex pause strap, default 1, sets both transmit and receive pause enables.
// - The port 0 full-duplex pause strap also sets the partner asymmetric pause and pause bits.
// - The port 0 manual pause strap, default 0, sets the port 0 manual select reset value.
// - The port 0 manual pause strap also sets the virtual phy pause advertisement bits.
// - In mii mac mode the port 0 manual pause strap is ignored and the host sets pause itself.
// - Only in mii phy mode the heartbeat strap sets the heartbeat-off bit, default 0.
// - Soft straps other than the duplex polarity strap may be replaced by the eeprom loader; the hard mode strap only at reset.
// - Port 0 mode code is 0 mii mac, 1 mii phy, 2 rmii phy, 3 reserved.
module port_flow_strap_defaults (
	input wire logic sys_clk,
	input wire logic reset,
	input wire strap_pkg::soft_straps_t strap_pins,
	input wire logic [1:0] mode_pins,
	input wire logic indication_pin_a,
	input wire logic ee_load,
	input wire strap_pkg::soft_straps_t ee_straps,
	input wire strap_pkg::sw_write_t sw_write,
	input wire logic p0_an_failed,
	input wire logic p0_an_speed_100,
	output strap_pkg::strap_regs_t regs_q,
	output strap_pkg::p0_mode_t p0_mode,
	output logic p0_speed_100_q,
	output logic p0_full_duplex_q
);
	import strap_pkg::*;

	soft_straps_t straps;
	p0_mode_t mode;
	logic indication_sync;
	logic load_defaults;
	strap_regs_t defaults;

	strap_capture u_capture (
		.sys_clk(sys_clk),
		.reset(reset),
		.strap_pins(strap_pins),
		.mode_pins(mode_pins),
		.indication_pin_a(indication_pin_a),
		.ee_load(ee_load),
		.ee_straps(ee_straps),
		.straps_q(straps),
		.mode_q(mode),
		.indication_sync(indication_sync),
		.load_defaults_q(load_defaults)
	);

	assign p0_mode = mode;

	// map straps and mode to register defaults; used for the load and the checks
	function automatic strap_regs_t derive(input soft_straps_t s, input p0_mode_t m);
		strap_regs_t r;
		logic mac;
		logic man0;
		mac = (m == MODE_MII_MAC);
		// host owns full-duplex pause in mac mode, so the strap is dropped
		man0 = s.p0_manual_pause_select_default & ~mac;
		r.p0_manual_pause_select = man0;
		r.p0_backpressure_enable = s.p0_backpressure_default;
		r.p0_transmit_pause_enable = s.p0_full_duplex_pause_default;
		r.p0_receive_pause_enable = s.p0_full_duplex_pause_default;
		r.p2_manual_pause_select = s.p2_manual_pause_select_default;
		// manual pause means no negotiated pause is advertised
		r.internal_phy_advertisement = {2{~s.p2_manual_pause_select_default}};
		r.virtual_phy_advertisement = {2{~man0}};
		r.virtual_phy_partner_ability[ABIL_ASYM] = s.p0_full_duplex_pause_default;
		r.virtual_phy_partner_ability[ABIL_PAUSE] = s.p0_full_duplex_pause_default;
		r.virtual_phy_partner_ability[ABIL_100FD] =
			s.p0_speed_100_default & s.indication_pin_a_pol_default;
		r.virtual_phy_partner_ability[ABIL_100HD] = s.p0_speed_100_default;
		r.virtual_phy_partner_ability[ABIL_10FD] = s.indication_pin_a_pol_default;
		r.virtual_phy_partner_ability[ABIL_10HD] = 1'b1;
		r.heartbeat_test_off =
			s.p0_heartbeat_test_off_default & (m == MODE_MII_PHY);
		return r;
	endfunction : derive

	assign defaults = derive(straps, mode);

	// true when software targets the given register this cycle
	function automatic logic hit(input sw_write_t w, input write_sel_t s);
		return w.valid && (w.sel == s);
	endfunction : hit

	// port 0 flow control register; a strap load wins over a same-cycle write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			regs_q.p0_manual_pause_select <= REGS_RESET.p0_manual_pause_select;
			regs_q.p0_backpressure_enable <= REGS_RESET.p0_backpressure_enable;
			regs_q.p0_transmit_pause_enable <= REGS_RESET.p0_transmit_pause_enable;
			regs_q.p0_receive_pause_enable <= REGS_RESET.p0_receive_pause_enable;
		end else if (load_defaults) begin
			regs_q.p0_manual_pause_select <= defaults.p0_manual_pause_select;
			regs_q.p0_backpressure_enable <= defaults.p0_backpressure_enable;
			regs_q.p0_transmit_pause_enable <= defaults.p0_transmit_pause_enable;
			regs_q.p0_receive_pause_enable <= defaults.p0_receive_pause_enable;
		end else if (hit(sw_write, SEL_P0_FLOW)) begin
			regs_q.p0_manual_pause_select <= sw_write.data[3];
			regs_q.p0_backpressure_enable <= sw_write.data[2];
			regs_q.p0_transmit_pause_enable <= sw_write.data[1];
			regs_q.p0_receive_pause_enable <= sw_write.data[0];
		end
	end

	// port 2 manual select bit
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			regs_q.p2_manual_pause_select <= REGS_RESET.p2_manual_pause_select;
		end else if (load_defaults) begin
			regs_q.p2_manual_pause_select <= defaults.p2_manual_pause_select;
		end else if (hit(sw_write, SEL_P2_FLOW)) begin
			regs_q.p2_manual_pause_select <= sw_write.data[0];
		end
	end

	// port 2 phy pause advertisement
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			regs_q.internal_phy_advertisement <= REGS_RESET.internal_phy_advertisement;
		end else if (load_defaults) begin
			regs_q.internal_phy_advertisement <= defaults.internal_phy_advertisement;
		end else if (hit(sw_write, SEL_PHY_ADV)) begin
			regs_q.internal_phy_advertisement <= sw_write.data[1:0];
		end
	end

	// virtual phy pause advertisement
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			regs_q.virtual_phy_advertisement <= REGS_RESET.virtual_phy_advertisement;
		end else if (load_defaults) begin
			regs_q.virtual_phy_advertisement <= defaults.virtual_phy_advertisement;
		end else if (hit(sw_write, SEL_VPHY_ADV)) begin
			regs_q.virtual_phy_advertisement <= sw_write.data[1:0];
		end
	end

	// virtual phy partner ability
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			regs_q.virtual_phy_partner_ability <= REGS_RESET.virtual_phy_partner_ability;
		end else if (load_defaults) begin
			regs_q.virtual_phy_partner_ability <= defaults.virtual_phy_partner_ability;
		end else if (hit(sw_write, SEL_VPHY_PARTNER)) begin
			regs_q.virtual_phy_partner_ability <= sw_write.data;
		end
	end

	// virtual phy heartbeat-off bit
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			regs_q.heartbeat_test_off <= REGS_RESET.heartbeat_test_off;
		end else if (load_defaults) begin
			regs_q.heartbeat_test_off <= defaults.heartbeat_test_off;
		end else if (hit(sw_write, SEL_VPHY_SPECIAL)) begin
			regs_q.heartbeat_test_off <= sw_write.data[0];
		end
	end

	// fall back to the strapped speed if negotiation gave up
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			p0_speed_100_q <= STRAP_RESET.p0_speed_100_default;
		end else if (p0_an_failed) begin
			p0_speed_100_q <= straps.p0_speed_100_default;
		end else begin
			p0_speed_100_q <= p0_an_speed_100;
		end
	end

	// duplex pin is meaningful only with an external phy; polarity 1 = high is full
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			p0_full_duplex_q <= 1'b0;
		end else if (mode == MODE_MII_MAC) begin
			p0_full_duplex_q <= (indication_sync == straps.indication_pin_a_pol_default);
		end else begin
			p0_full_duplex_q <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// a load puts the derived defaults into the registers one cycle later
	load_copies_a: assert property (load_defaults |=> regs_q == $past(defaults))
		else $error("strap defaults not loaded");

	p2_select_load_a: assert property (
		load_defaults |=> regs_q.p2_manual_pause_select ==
			$past(straps.p2_manual_pause_select_default))
		else $error("port 2 manual select default wrong");

	p2_adv_load_a: assert property (
		load_defaults && straps.p2_manual_pause_select_default
			|=> regs_q.internal_phy_advertisement == 2'h0)
		else $error("port 2 pause advertisement not cleared");

	speed_fallback_a: assert property (
		p0_an_failed |=> p0_speed_100_q == $past(straps.p0_speed_100_default))
		else $error("port 0 fallback speed wrong");

	duplex_pol_a: assert property (
		mode == MODE_MII_MAC && $stable(mode)
			|=> p0_full_duplex_q == ($past(indication_sync) == $past(straps.indication_pin_a_pol_default)))
		else $error("duplex pin polarity wrong");

	duplex_nonmac_a: assert property (
		mode != MODE_MII_MAC ##1 mode != MODE_MII_MAC |-> !p0_full_duplex_q)
		else $error("duplex flag outside mac mode");

	partner_speed_a: assert property (
		load_defaults |=> regs_q.virtual_phy_partner_ability[ABIL_100HD] ==
			$past(straps.p0_speed_100_default))
		else $error("partner 100 half ability wrong");

	partner_duplex_a: assert property (
		load_defaults |=> regs_q.virtual_phy_partner_ability[ABIL_10FD] ==
			$past(straps.indication_pin_a_pol_default))
		else $error("partner 10 full ability wrong");

	backpressure_load_a: assert property (
		load_defaults |=> regs_q.p0_backpressure_enable == $past(straps.p0_backpressure_default))
		else $error("backpressure default wrong");

	pause_pair_a: assert property (
		load_defaults |=> regs_q.p0_transmit_pause_enable == regs_q.p0_receive_pause_enable
			&& regs_q.p0_receive_pause_enable == $past(straps.p0_full_duplex_pause_default))
		else $error("transmit and receive pause defaults differ");

	partner_pause_a: assert property (
		load_defaults |=> regs_q.virtual_phy_partner_ability[ABIL_ASYM:ABIL_PAUSE] ==
			{2{$past(straps.p0_full_duplex_pause_default)}})
		else $error("partner pause defaults wrong");

	p0_select_load_a: assert property (
		load_defaults && mode != MODE_MII_MAC |=> regs_q.p0_manual_pause_select ==
			$past(straps.p0_manual_pause_select_default))
		else $error("port 0 manual select default wrong");

	vphy_adv_load_a: assert property (
		load_defaults |=> regs_q.virtual_phy_advertisement == {2{~($past(mode) != MODE_MII_MAC
			&& $past(straps.p0_manual_pause_select_default))}})
		else $error("virtual phy advertisement default wrong");

	mac_ignores_manual_a: assert property (
		load_defaults && mode == MODE_MII_MAC |=> !regs_q.p0_manual_pause_select)
		else $error("manual strap used in mac mode");

	heartbeat_mode_a: assert property (
		load_defaults && mode != MODE_MII_PHY |=> !regs_q.heartbeat_test_off)
		else $error("heartbeat strap used outside mii phy");

	mode_held_a: assert property ($stable(mode))
		else $error("hard mode strap changed outside reset");

	sw_write_sticks_a: assert property (
		hit(sw_write, SEL_P2_FLOW) && !load_defaults
			|=> regs_q.p2_manual_pause_select == $past(sw_write.data[0]))
		else $error("software write lost");

	// software writes land in the port 0 flow bits unless a load is due
	p0_write_a: assert property (
		hit(sw_write, SEL_P0_FLOW) && !load_defaults |=> {regs_q.p0_manual_pause_select,
			regs_q.p0_backpressure_enable, regs_q.p0_transmit_pause_enable,
			regs_q.p0_receive_pause_enable} == $past(sw_write.data[3:0]))
		else $error("port 0 flow write lost");

	// a write in the load cycle must not survive the load
	load_beats_write_a: assert property (
		load_defaults && hit(sw_write, SEL_P2_FLOW) |=> regs_q.p2_manual_pause_select ==
			$past(defaults.p2_manual_pause_select))
		else $error("write beat the strap load");

	p2_adv_open_a: assert property (
		load_defaults && !straps.p2_manual_pause_select_default
			|=> regs_q.internal_phy_advertisement == 2'h3)
		else $error("port 2 pause advertisement not set");

	heartbeat_phy_a: assert property (
		load_defaults && mode == MODE_MII_PHY |=> regs_q.heartbeat_test_off ==
			$past(straps.p0_heartbeat_test_off_default))
		else $error("heartbeat default wrong in mii phy");

	partner_full_a: assert property (
		load_defaults |=> regs_q.virtual_phy_partner_ability[ABIL_100FD] ==
			($past(straps.p0_speed_100_default) && $past(straps.indication_pin_a_pol_default)))
		else $error("partner 100 full ability wrong");

	// loader replaces soft straps but the polarity strap keeps its pin value
	loader_straps_a: assert property (
		ee_load |=> straps.p0_backpressure_default ==
			$past(ee_straps.p0_backpressure_default)
			&& straps.indication_pin_a_pol_default == $past(straps.indication_pin_a_pol_default))
		else $error("loader strap update wrong");

	// each reset release and each loader update asks for one reload
	release_load_a: assert property ($fell(reset) |=> load_defaults)
		else $error("no load after reset release");

	loader_reload_a: assert property (ee_load |=> load_defaults)
		else $error("no load after loader update");

endmodule : port_flow_strap_defaults

// ---- strap_board.sv ----
// board model: strap resistors, duplex indication pin and eeprom loader
module strap_board (
	input wire logic sys_clk,
	output strap_pkg::soft_straps_t strap_pins,
	output logic [1:0] mode_pins,
	output logic indication_pin_a,
	output logic ee_load,
	output strap_pkg::soft_straps_t ee_straps
);
	timeunit 1ns;
	timeprecision 1ps;
	import strap_pkg::*;

	// resistors at their default levels until a test sets them
	initial begin
		strap_pins = STRAP_RESET;
		mode_pins = 2'h1;
		indication_pin_a = 1'b0;
		ee_load = 1'b0;
		ee_straps = STRAP_RESET;
	end

	// strap levels and mode code, called at a falling edge
	task automatic set_pins(input soft_straps_t s, input logic [1:0] m);
		strap_pins = s;
		mode_pins = m;
	endtask : set_pins

	task automatic set_dup(input logic d);
		indication_pin_a = d;
	endtask : set_dup

	// one-cycle load; the data lines are then scrambled, not left holding
	task automatic load(input soft_straps_t v);
		ee_straps = v;
		ee_load = 1'b1;
		@(negedge sys_clk);
		ee_load = 1'b0;
		ee_straps = ~v;
	endtask : load
endmodule : strap_board

// ---- testbench.sv ----
// self-checking bench for the soft-strap default logic
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import strap_pkg::*;

	typedef struct packed {
		strap_regs_t regs;
		p0_mode_t mode;
		logic spd;
		logic dup;
	} exp_t;

	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic p0_an_failed = 1'b0;
	logic p0_an_speed_100 = 1'b0;
	sw_write_t sw_write = '0;
	soft_straps_t strap_pins, ee_straps, s, v;
	logic [1:0] mode_pins;
	logic indication_pin_a, ee_load;
	strap_regs_t regs_q, r;
	p0_mode_t p0_mode, m;
	logic p0_speed_100_q, p0_full_duplex_q;
	logic [5:0] d;
	exp_t exp_q[$];
	exp_t e;
	int n_errors = 0;
	int tests_run = 0;

	always #2.5 sys_clk = ~sys_clk;

	port_flow_strap_defaults dut (.sys_clk(sys_clk), .reset(reset), .strap_pins(strap_pins),
		.mode_pins(mode_pins), .indication_pin_a(indication_pin_a), .ee_load(ee_load),
		.ee_straps(ee_straps), .sw_write(sw_write), .p0_an_failed(p0_an_failed),
		.p0_an_speed_100(p0_an_speed_100), .regs_q(regs_q), .p0_mode(p0_mode),
		.p0_speed_100_q(p0_speed_100_q), .p0_full_duplex_q(p0_full_duplex_q));

	strap_board board (.sys_clk(sys_clk), .strap_pins(strap_pins), .mode_pins(mode_pins),
		.indication_pin_a(indication_pin_a), .ee_load(ee_load), .ee_straps(ee_straps));

	// defaults the registers should take from a given strap set
	function automatic strap_regs_t derive(input soft_straps_t t, input p0_mode_t md);
		strap_regs_t x;
		logic man;
		man = (md == MODE_MII_MAC) ? 1'b0 : t.p0_manual_pause_select_default;
		x.p0_manual_pause_select = man;
		x.p0_backpressure_enable = t.p0_backpressure_default;
		x.p0_transmit_pause_enable = t.p0_full_duplex_pause_default;
		x.p0_receive_pause_enable = t.p0_full_duplex_pause_default;
		x.p2_manual_pause_select = t.p2_manual_pause_select_default;
		x.internal_phy_advertisement = {2{~t.p2_manual_pause_select_default}};
		x.virtual_phy_advertisement = {2{~man}};
		x.virtual_phy_partner_ability = {{2{t.p0_full_duplex_pause_default}},
			t.p0_speed_100_default & t.indication_pin_a_pol_default, t.p0_speed_100_default,
			t.indication_pin_a_pol_default, 1'b1};
		x.heartbeat_test_off = (md == MODE_MII_PHY) & t.p0_heartbeat_test_off_default;
		return x;
	endfunction : derive

	// let the outputs settle, including the duplex pin synchroniser, then note the result
	task automatic chk();
		repeat (4) @(negedge sys_clk);
		e.regs = r;
		e.mode = m;
		e.spd = p0_an_failed ? s.p0_speed_100_default : p0_an_speed_100;
		e.dup = (m == MODE_MII_MAC) && (indication_pin_a == s.indication_pin_a_pol_default);
		exp_q.push_back(e);
	endtask : chk

	// reset long enough for the synced straps to reach the latch
	task automatic do_reset(input soft_straps_t t, input logic [1:0] md);
		board.set_pins(t, md);
		reset = 1'b1;
		m = p0_mode_t'(md);
		repeat (6) @(negedge sys_clk);
		exp_q.push_back({derive(STRAP_RESET, MODE_MII_PHY), m, 2'b10});
		reset = 1'b0;
		s = t;
		r = derive(s, m);
		chk();
	endtask : do_reset

	task automatic cmp(input string name, input logic [15:0] ex, input logic [15:0] got);
		tests_run++;
		if (got !== ex) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, ex, got);
		end
	endtask : cmp

	// monitor: every noted result is compared against what the outputs show now
	initial begin
		exp_t x;
		forever begin
			wait (exp_q.size() != 0);
			x = exp_q.pop_front();
			cmp("regs_q", x.regs, regs_q);
			cmp("p0_mode", x.mode, p0_mode);
			cmp("p0_speed_100_q", x.spd, p0_speed_100_q);
			cmp("p0_full_duplex_q", x.dup, p0_full_duplex_q);
		end
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		n_errors++;
		results();
	end

	initial begin
		void'($urandom(78));
		repeat (2) @(negedge sys_clk);
		for (int mi = 0; mi < 4; mi++) begin
			// all-ones first: manual strap set in mac mode must still be ignored
			for (int k = 0; k < 4; k++) begin
				do_reset((k == 0) ? 7'h7f : 7'($urandom), 2'(mi));
			end
			// pin changes after release must not reach the registers
			board.set_pins(~s, ~2'(mi));
			chk();
			for (int j = 0; j < 2; j++) begin
				board.set_dup(j[0]);
				chk();
			end
			for (int j = 0; j < 4; j++) begin
				{p0_an_failed, p0_an_speed_100} = 2'(j);
				chk();
			end
			// back-to-back writes to every selector, reserved codes included
			for (int sel = 0; sel < 8; sel++) begin
				d = 6'($urandom);
				sw_write = {1'b1, 3'(sel), d};
				case (sel)
					0: {r.p0_manual_pause_select, r.p0_backpressure_enable,
						r.p0_transmit_pause_enable, r.p0_receive_pause_enable} = d[3:0];
					1: r.p2_manual_pause_select = d[0];
					2: r.internal_phy_advertisement = d[1:0];
					3: r.virtual_phy_advertisement = d[1:0];
					4: r.virtual_phy_partner_ability = d;
					5: r.heartbeat_test_off = d[0];
					default: ;
				endcase
				@(negedge sys_clk);
			end
			sw_write = '0;
			chk();
			// loader replaces soft straps and discards the writes; polarity stays with its pin
			v = 7'($urandom);
			v.indication_pin_a_pol_default = ~s.indication_pin_a_pol_default;
			board.load(v);
			v.indication_pin_a_pol_default = s.indication_pin_a_pol_default;
			s = v;
			r = derive(s, m);
			// a write in the load cycle is lost to the load
			d = 6'($urandom);
			d[0] = ~r.p2_manual_pause_select;
			sw_write = {1'b1, SEL_P2_FLOW, d};
			@(negedge sys_clk);
			sw_write = '0;
			chk();
			$display("test mode %0d done", mi);
		end
		repeat (2) @(negedge sys_clk);
		results();
	end
endmodule : testbench
